// File: include/lcd_timing_pkg.sv
// Purpose: shared constants for the lcd multiplex frame timing core
// Assumes: system clock of 250 MHz; drive levels are bias ladder taps
// Notes:   level code 0 is the positive supply, 3 the lcd supply
package lcd_timing_pkg;
    // system clock and internal oscillator rates
    localparam int unsigned SYS_HZ    = 250_000_000;
    localparam int unsigned OSC_HZ    = 200_000;   // normal mode oscillator
    localparam int unsigned OSC_PS_HZ = 31_000;    // power-saving oscillator
    // half periods of the internal oscillator, rounded down
    localparam logic [11:0] OSC_HALF    = 12'(SYS_HZ / (2 * OSC_HZ));
    localparam logic [11:0] OSC_PS_HALF = 12'(SYS_HZ / (2 * OSC_PS_HZ));

    // working clocks per frame, and per slot for 1:3 mode
    localparam logic [11:0] DIV_NORMAL = 12'd2880;
    localparam logic [11:0] DIV_PS     = 12'd480;
    localparam logic [11:0] DIV_NORMAL_3 = 12'(2880 / 3);
    localparam logic [11:0] DIV_PS_3     = 12'(480 / 3);

    // drive mode encodings
    localparam logic [1:0] MODE_MUX4   = 2'h0;
    localparam logic [1:0] MODE_STATIC = 2'h1;
    localparam logic [1:0] MODE_MUX2   = 2'h2;
    localparam logic [1:0] MODE_MUX3   = 2'h3;

    // bias ladder taps; with half bias taps 1 and 2 coincide
    localparam logic [1:0] LVL_VDD = 2'h0;
    localparam logic [1:0] LVL_13  = 2'h1;
    localparam logic [1:0] LVL_23  = 2'h2;
    localparam logic [1:0] LVL_LCD = 2'h3;

    // geometry
    localparam int unsigned NUM_SEG  = 24;
    localparam int unsigned NUM_BP   = 4;
    localparam logic [4:0]  SEG_LAST = 5'd23;

    // reset values
    localparam logic [1:0] RST_MODE = MODE_MUX4;
    localparam logic       RST_HALF = 1'b0;
endpackage : lcd_timing_pkg

// File: core/lcd_multiplex_frame_timing.sv
// Purpose: frame timing, display register and lcd drive sequencing
// Assumes: mode, bias and ram writes come from logic on clk
// Notes:   outputs are 2-bit bias ladder tap codes per pin
//
// Summary of operation
// - one system clock times all logic
// - frame is 2880 or 480 working clocks
// - internal clock follows mode; external follows pin
// - select low: internal oscillator, drive clock pin
// - select high: clock pin is input
// - hold scl low while a byte waits behind an unstored one
// - cascade sync keeps chips aligned
// - display register holds one ram column
// - shift register preloads next column meanwhile
// - 24 segments from phase and register bit
// - static: one backplane, two levels
// - 1:2 uses two backplanes, half/third bias
// - 1:3 uses three backplanes, third bias
// - 1:4 uses four backplanes, third bias
// - 1:3 and 1:4 allow half bias
// - ram rows 0-3 with backplanes 0-3
// - 1:3: backplane 3 copies backplane 1
// - 1:2: pairs 0/2 and 1/3 identical
// - reset: 1:4 mode, outputs at supply
`timescale 1ns/1ps
module lcd_multiplex_frame_timing (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        osc_select,
    input  wire logic        clk_pin_in,
    output logic             clk_pin_out,
    output logic             clk_pin_oe,
    input  wire logic [1:0]  mux_mode,
    input  wire logic        half_bias,
    input  wire logic        power_save,
    input  wire logic        wr_valid,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [3:0]  wr_data,
    output logic             scl_hold,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    output logic [7:0]       backplane_outputs,
    output logic [47:0]      segment_outputs,
    output logic             frame_rate
);

    // working clocks per slot for the latched mode
    function automatic logic [11:0] slot_len(input logic [1:0] m, input logic ps);
        logic [11:0] d;
        d = ps ? lcd_timing_pkg::DIV_PS : lcd_timing_pkg::DIV_NORMAL;
        case (m)
            lcd_timing_pkg::MODE_STATIC: slot_len = d;
            lcd_timing_pkg::MODE_MUX2:   slot_len = {1'b0, d[11:1]};
            lcd_timing_pkg::MODE_MUX3:   slot_len = ps ? lcd_timing_pkg::DIV_PS_3
                                                       : lcd_timing_pkg::DIV_NORMAL_3;
            default:                     slot_len = {2'b00, d[11:2]};
        endcase
    endfunction : slot_len

    // index of the last slot in a frame
    function automatic logic [1:0] last_slot(input logic [1:0] m);
        case (m)
            lcd_timing_pkg::MODE_STATIC: last_slot = 2'h0;
            lcd_timing_pkg::MODE_MUX2:   last_slot = 2'h1;
            lcd_timing_pkg::MODE_MUX3:   last_slot = 2'h2;
            default:                     last_slot = 2'h3;
        endcase
    endfunction : last_slot

    // slot in which backplane k is selected
    function automatic logic [1:0] bp_slot(input logic [1:0] k, input logic [1:0] m);
        case (m)
            lcd_timing_pkg::MODE_STATIC: bp_slot = 2'h0;
            lcd_timing_pkg::MODE_MUX2:   bp_slot = {1'b0, k[0]};
            lcd_timing_pkg::MODE_MUX3:   bp_slot = (k == 2'h3) ? 2'h1 : k;
            default:                     bp_slot = k;
        endcase
    endfunction : bp_slot

    // backplane tap: selected swings full scale, idle sits mid ladder
    function automatic logic [1:0] bp_level(input logic sel, input logic pol,
                                            input logic half);
        if (sel)
            bp_level = pol ? lcd_timing_pkg::LVL_LCD : lcd_timing_pkg::LVL_VDD;
        else if (half)
            bp_level = lcd_timing_pkg::LVL_13;
        else
            bp_level = pol ? lcd_timing_pkg::LVL_13 : lcd_timing_pkg::LVL_23;
    endfunction : bp_level

    // segment tap: on opposes the selected backplane
    function automatic logic [1:0] seg_level(input logic on, input logic pol,
                                             input logic half, input logic stat);
        if (on)
            seg_level = pol ? lcd_timing_pkg::LVL_VDD : lcd_timing_pkg::LVL_LCD;
        else if (stat)
            seg_level = pol ? lcd_timing_pkg::LVL_LCD : lcd_timing_pkg::LVL_VDD;
        else if (half)
            seg_level = lcd_timing_pkg::LVL_13;
        else
            seg_level = pol ? lcd_timing_pkg::LVL_23 : lcd_timing_pkg::LVL_13;
    endfunction : seg_level

    logic        osc_sel_s1;
    logic        osc_sel_s2;
    logic        clkp_s1;
    logic        clkp_s2;
    logic        clkp_d;
    logic        sync_s1;
    logic        sync_s2;
    logic        sync_d;
    logic [11:0] osc_cnt;
    logic        osc_level;
    logic        tick;
    logic [1:0]  mode_q;
    logic        half_q;
    logic        ps_q;
    logic [11:0] tick_cnt;
    logic [1:0]  slot;
    logic        pol;
    logic        slot_end;
    logic        frame_end;
    logic        drive_upd;
    logic        sync_fall;
    logic [1:0]  next_row;
    logic [3:0]  ram [lcd_timing_pkg::NUM_SEG];
    logic [23:0] shift_reg;
    logic [23:0] disp_reg;
    logic [4:0]  shift_idx;
    logic        pend_a;
    logic [4:0]  addr_a;
    logic [3:0]  data_a;
    logic        pend_b;
    logic [4:0]  addr_b;
    logic [3:0]  data_b;

    // pin inputs pass two flops; the third stage feeds edge detection only
    always_ff @(posedge clk) begin
        osc_sel_s1 <= osc_select;
        osc_sel_s2 <= osc_sel_s1;
        clkp_s1    <= clk_pin_in;
        clkp_s2    <= clkp_s1;
        clkp_d     <= clkp_s2;
        sync_s1    <= sync_in;
        sync_s2    <= sync_s1;
        sync_d     <= sync_s2;
    end

    // internal oscillator; its rate follows power-saving mode
    always_ff @(posedge clk) begin
        if (sys_rst || osc_sel_s2) begin
            osc_cnt   <= 12'h000;
            osc_level <= 1'b0;
        end else if (osc_cnt >= (power_save ? lcd_timing_pkg::OSC_PS_HALF
                                            : lcd_timing_pkg::OSC_HALF) - 12'h001) begin
            osc_cnt   <= 12'h000;
            osc_level <= ~osc_level;
        end else begin
            osc_cnt   <= osc_cnt + 12'h001;
        end
    end

    // clock pin: driven out for cascades only when internal source chosen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_pin_out <= 1'b0;
            clk_pin_oe  <= 1'b0;
        end else begin
            clk_pin_out <= osc_level;
            clk_pin_oe  <= ~osc_sel_s2;
        end
    end

    // one working clock tick per rising edge of the chosen source
    always_ff @(posedge clk) begin
        if (sys_rst)
            tick <= 1'b0;
        else if (osc_sel_s2)
            tick <= clkp_s2 & ~clkp_d;
        else
            tick <= ~osc_level & (osc_cnt == (power_save ? lcd_timing_pkg::OSC_PS_HALF
                                   : lcd_timing_pkg::OSC_HALF) - 12'h001);
    end

    assign slot_end  = tick && (tick_cnt == slot_len(mode_q, ps_q) - 12'h001);
    assign frame_end = slot_end && (slot == last_slot(mode_q));
    // another chip pulling sync low marks its frame start
    assign sync_fall = sync_d & ~sync_s2 & (slot != 2'h0);
    assign next_row  = (slot == last_slot(mode_q)) ? 2'h0 : slot + 2'h1;

    // slot and frame counters; mode changes only take effect at frame start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt <= 12'h000;
            slot     <= 2'h0;
            pol      <= 1'b0;
            mode_q   <= lcd_timing_pkg::RST_MODE;
            half_q   <= lcd_timing_pkg::RST_HALF;
            ps_q     <= 1'b0;
        end else if (sync_fall) begin
            tick_cnt <= 12'h000;
            slot     <= 2'h0;
        end else if (frame_end) begin
            tick_cnt <= 12'h000;
            slot     <= 2'h0;
            pol      <= ~pol;      // alternate frames keep the panel dc free
            mode_q   <= mux_mode;
            half_q   <= half_bias | (mux_mode == lcd_timing_pkg::MODE_STATIC);
            ps_q     <= power_save;
        end else if (slot_end) begin
            tick_cnt <= 12'h000;
            slot     <= slot + 2'h1;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 12'h001;
        end
    end

    // open-drain sync: pull low through slot 0 of each frame
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_out <= 1'b0;
            sync_oe  <= 1'b0;
        end else begin
            sync_out <= 1'b0;
            sync_oe  <= (slot == 2'h0);
        end
    end

    // frame strobe, one clk wide
    always_ff @(posedge clk) begin
        if (sys_rst)
            frame_rate <= 1'b0;
        else
            frame_rate <= frame_end;
    end

    // two-deep byte holding; the second slot only fills while stretching
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            addr_a <= 5'h00;
            data_a <= 4'h0;
            addr_b <= 5'h00;
            data_b <= 4'h0;
        end else begin
            if (tick && pend_a) begin
                pend_a <= pend_b | wr_valid;
                addr_a <= pend_b ? addr_b : wr_addr;
                data_a <= pend_b ? data_b : wr_data;
                pend_b <= pend_b & wr_valid;
            end else if (wr_valid && !pend_a) begin
                pend_a <= 1'b1;
                addr_a <= wr_addr;
                data_a <= wr_data;
            end else if (wr_valid) begin
                pend_b <= 1'b1;
            end
            if (wr_valid && pend_a && !(tick && pend_b)) begin
                addr_b <= wr_addr;
                data_b <= wr_data;
            end
        end
    end

    // scl is stretched while a byte waits behind an unstored one
    always_ff @(posedge clk) begin
        if (sys_rst)
            scl_hold <= 1'b0;
        else
            scl_hold <= pend_b | (wr_valid & pend_a);
    end

    // ram stores are paced by the working clock
    always_ff @(posedge clk) begin
        if (tick && pend_a && addr_a <= lcd_timing_pkg::SEG_LAST)
            ram[addr_a] <= data_a;
    end

    // serial preload of the next column, one segment per tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_reg <= 24'h000000;
            disp_reg  <= 24'h000000;
            shift_idx <= 5'h00;
        end else if (slot_end || sync_fall) begin
            disp_reg  <= shift_reg;
            shift_idx <= 5'h00;
        end else if (tick && shift_idx <= lcd_timing_pkg::SEG_LAST) begin
            shift_reg <= {ram[shift_idx][next_row], shift_reg[23:1]};
            shift_idx <= shift_idx + 5'h01;
        end
    end

    // outputs refresh the clk after a slot change, so disp_reg is settled
    always_ff @(posedge clk) begin
        if (sys_rst)
            drive_upd <= 1'b0;
        else
            drive_upd <= slot_end | sync_fall;
    end

    // backplane drive; idle at supply until the first slot completes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            backplane_outputs <= {8{1'b0}};
        end else if (drive_upd) begin
            for (int k = 0; k < lcd_timing_pkg::NUM_BP; k++)
                backplane_outputs[2*k +: 2] <=
                    bp_level(bp_slot(2'(k), mode_q) == slot, pol, half_q);
        end
    end

    // segment drive from register bit and current phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            segment_outputs <= {48{1'b0}};
        end else if (drive_upd) begin
            for (int s = 0; s < lcd_timing_pkg::NUM_SEG; s++)
                segment_outputs[2*s +: 2] <= seg_level(disp_reg[s], pol, half_q,
                    mode_q == lcd_timing_pkg::MODE_STATIC);
        end
    end

endmodule : lcd_multiplex_frame_timing

// File: sim/lcd_frame_checker.sv
// Purpose: port checks for the lcd frame timing core
// Assumes: a new mode shows after the next frame end
// Notes:   attached to the core by bind at the foot
`timescale 1ns/1ps
module lcd_frame_checker (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        osc_select,
    input  wire logic [1:0]  mux_mode,
    input  wire logic        wr_valid,
    input  wire logic        scl_hold,
    input  wire logic        clk_pin_oe,
    input  wire logic        sync_out,
    input  wire logic        sync_oe,
    input  wire logic [7:0]  backplane_outputs,
    input  wire logic [47:0] segment_outputs,
    input  wire logic        frame_rate
);
    logic [1:0] age;
    logic [1:0] mode_seen;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // frame ends since the mode input moved; pairing is only judged once settled
    always_ff @(posedge clk) begin
        mode_seen <= mux_mode;
        if (sys_rst || mux_mode != mode_seen) age <= 2'h0;
        else if (frame_rate && age != 2'h2) age <= age + 2'h1;
    end
    a_reset_drive_idle: assert property ($fell(sys_rst) |-> backplane_outputs == 8'h00
        && segment_outputs == 48'h0 && !frame_rate) else $error("drive not idle after reset");
    a_frame_pulse_one: assert property (frame_rate |=> !frame_rate)
        else $error("frame pulse longer than one clock");
    a_pin_drive_int: assert property ((!osc_select)[*5] |-> clk_pin_oe)
        else $error("clock pin not driven with internal oscillator");
    a_pin_input_ext: assert property (osc_select[*5] |-> !clk_pin_oe)
        else $error("clock pin driven with external clock");
    // mode_seen lags the input by one clk, so the edge of a mode change is judged on the old mode
    a_mux3_bp_copy: assert property ((age == 2'h2 && mode_seen == lcd_timing_pkg::MODE_MUX3)
        |-> backplane_outputs[7:6] == backplane_outputs[3:2]) else $error("backplane 3 differs from 1");
    a_mux2_bp_pairs: assert property ((age == 2'h2 && mode_seen == lcd_timing_pkg::MODE_MUX2)
        |-> backplane_outputs[5:4] == backplane_outputs[1:0] && backplane_outputs[7:6] == backplane_outputs[3:2])
        else $error("backplane pairs differ");
    a_static_bp_same: assert property ((age == 2'h2 && mode_seen == lcd_timing_pkg::MODE_STATIC)
        |-> backplane_outputs == {4{backplane_outputs[1:0]}} && backplane_outputs[0] == backplane_outputs[1])
        else $error("static backplanes not equal two-level");
    a_scl_hold_cause: assert property ($rose(scl_hold) |-> $past(wr_valid))
        else $error("scl hold without a write");
    a_sync_pull_low: assert property (sync_oe |-> !sync_out)
        else $error("sync driven high");
    a_sync_in_slot0: assert property (frame_rate |-> ##[0:2] sync_oe)
        else $error("sync not pulled at frame start");
endmodule : lcd_frame_checker
bind lcd_multiplex_frame_timing lcd_frame_checker u_lcd_frame_checker (.clk(clk), .sys_rst(sys_rst),
    .osc_select(osc_select), .mux_mode(mux_mode), .wr_valid(wr_valid), .scl_hold(scl_hold),
    .clk_pin_oe(clk_pin_oe), .sync_out(sync_out), .sync_oe(sync_oe),
    .backplane_outputs(backplane_outputs), .segment_outputs(segment_outputs), .frame_rate(frame_rate));

// File: sim/lcd_far_side.sv
// Purpose: far side model: external clock source and a cascaded chip
// Assumes: sync wire has a pull-up
// Notes:   the clock runs free, it is never stopped
`timescale 1ns/1ps
module lcd_far_side #(parameter int HALF = 2) (
    input  wire logic clk,
    input  wire logic pull,
    input  wire logic clk_pin_oe,
    input  wire logic clk_pin_out,
    input  wire logic sync_out,
    input  wire logic sync_oe,
    output logic      clk_pin_in,
    output logic      sync_in
);
    int   cnt = 0;
    logic ext = 1'b0;
    // external working clock far above the minimum rate
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) ext <= ~ext;
    end
    // pin carries the driving party; sync is wired-and with a pull-up
    assign clk_pin_in = clk_pin_oe ? clk_pin_out : ext;
    assign sync_in    = !(sync_oe && !sync_out) && !pull;
endmodule : lcd_far_side

// File: sim/tb_lcd_multiplex_frame_timing.sv
// Purpose: self-checking bench for the lcd frame timing core
// Assumes: far side gives one working tick every 4 clk
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_lcd_multiplex_frame_timing;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        osc_select = 1'b1;
    logic        clk_pin_in, clk_pin_out, clk_pin_oe, scl_hold, sync_in, sync_out, sync_oe, frame_rate;
    logic [1:0]  mux_mode = lcd_timing_pkg::MODE_MUX4;
    logic        half_bias = 1'b0;
    logic        power_save = 1'b1;
    logic        wr_valid = 1'b0;
    logic [4:0]  wr_addr = 5'h00;
    logic [3:0]  wr_data = 4'h0;
    logic        pull = 1'b0;
    logic [7:0]  backplane_outputs;
    logic [47:0] segment_outputs;
    logic [3:0]  ram [24];
    logic [1:0]  modes [4] = '{lcd_timing_pkg::MODE_STATIC, lcd_timing_pkg::MODE_MUX2,
                               lcd_timing_pkg::MODE_MUX3, lcd_timing_pkg::MODE_MUX4};
    int          bad_count = 0;
    int          num_checks = 0;
    int          seed = 32'h7622;
    int          n;
    logic        pol;
    always #2 clk = ~clk;
    lcd_multiplex_frame_timing u_lcd_multiplex_frame_timing (.clk(clk), .sys_rst(sys_rst),
        .osc_select(osc_select), .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
        .mux_mode(mux_mode), .half_bias(half_bias), .power_save(power_save), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .scl_hold(scl_hold), .sync_in(sync_in), .sync_out(sync_out),
        .sync_oe(sync_oe), .backplane_outputs(backplane_outputs), .segment_outputs(segment_outputs),
        .frame_rate(frame_rate));
    lcd_far_side u_lcd_far_side (.clk(clk), .pull(pull), .clk_pin_oe(clk_pin_oe), .clk_pin_out(clk_pin_out),
        .sync_out(sync_out), .sync_oe(sync_oe), .clk_pin_in(clk_pin_in), .sync_in(sync_in));
    // verdict in one place
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        num_checks++;
        if (exp !== got) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // bounded wait; len is the number of falling edges passed
    task automatic wait_for(ref logic sig, input logic val, input int lim, output int len);
        for (len = 1; len <= lim; len++) begin
            @(negedge clk);
            if (sig === val) break;
        end
        chk("wait bound", 48'h1, 48'(len <= lim));
        if (len > lim) final_report();
    endtask : wait_for
    // expected ladder taps; j folds unused backplanes onto their partners
    function automatic logic [1:0] exp_bp(input int k, input int s);
        int j;
        j = (n == 2) ? k % 2 : (n == 3 && k == 3) ? 1 : k;
        if (n == 1 || j == s) return pol ? 2'h3 : 2'h0;
        return half_bias ? 2'h1 : (pol ? 2'h1 : 2'h2);
    endfunction : exp_bp
    function automatic logic [1:0] exp_seg(input logic on);
        if (n == 1) return (on ^ pol) ? 2'h3 : 2'h0;
        if (on) return pol ? 2'h0 : 2'h3;
        return half_bias ? 2'h1 : (pol ? 2'h2 : 2'h1);
    endfunction : exp_seg
    // one whole frame, slot by slot, against the ram model
    task automatic check_frame;
        int len, s, k;
        n = (mux_mode == lcd_timing_pkg::MODE_STATIC) ? 1 : (mux_mode == lcd_timing_pkg::MODE_MUX2) ? 2 :
            (mux_mode == lcd_timing_pkg::MODE_MUX3) ? 3 : 4;
        wait_for(frame_rate, 1'b1, 30000, len);
        repeat (4) @(negedge clk);
        pol = (backplane_outputs[1:0] == 2'h3);
        for (s = 0; s < n; s++) begin
            for (k = 0; k < 4; k++) chk("backplane", 48'(exp_bp(k, s)), 48'(backplane_outputs[2*k +: 2]));
            for (k = 0; k < 24; k++) chk("segment", 48'(exp_seg(ram[k][s])), 48'(segment_outputs[2*k +: 2]));
            repeat ((power_save ? 1920 : 11520) / n) @(negedge clk);
        end
    endtask : check_frame
    initial begin
        int len, i;
        logic v;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk("reset backplanes", 48'h0, 48'(backplane_outputs));
        chk("reset segments", 48'h0, segment_outputs);
        // fill the ram with spaced writes, then one to a missing column
        for (i = 0; i < 24; i++) begin
            ram[i] = 4'($random(seed));
            wr_valid = 1'b1;
            wr_addr = 5'(i);
            wr_data = ram[i];
            @(negedge clk);
            wr_valid = 1'b0;
            repeat (8) @(negedge clk);
        end
        wr_valid = 1'b1;
        wr_addr = 5'h1f;
        wr_data = 4'hf;
        @(negedge clk);
        wr_valid = 1'b0;
        wait_for(frame_rate, 1'b1, 30000, len);
        wait_for(frame_rate, 1'b1, 30000, len);
        chk("saving frame length", 48'd1920, 48'(len));
        foreach (modes[m]) begin
            mux_mode = modes[m];
            half_bias = 1'($random(seed));
            wait_for(frame_rate, 1'b1, 30000, len);
            check_frame();
        end
        // a cascaded chip pulls sync in mid-frame
        wait_for(frame_rate, 1'b1, 30000, len);
        repeat (600) @(negedge clk);
        pull = 1'b1;
        wait_for(sync_oe, 1'b1, 12, len);
        pull = 1'b0;
        power_save = 1'b0;
        wait_for(frame_rate, 1'b1, 30000, len);
        wait_for(frame_rate, 1'b1, 30000, len);
        chk("normal frame length", 48'd11520, 48'(len));
        // internal oscillator: slow ticks make a back-to-back write wait
        osc_select = 1'b0;
        repeat (6) @(negedge clk);
        chk("pin drive", 48'h1, 48'(clk_pin_oe));
        v = clk_pin_out;
        wait_for(clk_pin_out, ~v, 1300, len);
        ram[2] = ~ram[2];
        ram[3] = ~ram[3];
        wr_valid = 1'b1;
        wr_addr = 5'h02;
        wr_data = ram[2];
        @(negedge clk);
        wr_addr = 5'h03;
        wr_data = ram[3];
        @(negedge clk);
        wr_valid = 1'b0;
        wait_for(scl_hold, 1'b1, 2, len);
        wait_for(scl_hold, 1'b0, 3000, len);
        osc_select = 1'b1;
        repeat (6) @(negedge clk);
        chk("pin input", 48'h0, 48'(clk_pin_oe));
        check_frame();
        final_report();
    end
endmodule : tb_lcd_multiplex_frame_timing
